// *** hdl/tpc_params.svh ***
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH
// register byte offsets
`define TPC_OFF_CTL0 12'h000
`define TPC_OFF_CTL1 12'h004
`define TPC_OFF_CNT 12'h008
`define TPC_OFF_PWM 12'h00c
`define TPC_OFF_RLD 12'h010
`define TPC_OFF_DBND 12'h014
// control 0 fields
`define TPC_C0_EN 7
`define TPC_C0_POL 6
`define TPC_C0_PRE_LO 3
`define TPC_C0_PRE_HI 5
`define TPC_C0_MODE_LO 0
`define TPC_C0_MODE_HI 2
// control 1 fields
`define TPC_C1_MODEHI 7
`define TPC_C1_OUTEN 0
// reset and restart values
`define TPC_CNT_RESTART 16'h0001
`define TPC_CNT_RST 16'h0000
`define TPC_RLD_RST 16'hffff
`define TPC_PWM_RST 16'h0000
`define TPC_CTL_RST 8'h00
`define TPC_DB_RST 8'h00
`define TPC_DB_MAX 8'h80
// mode codes {modehi, mode[2:0]}
`define TPC_MODE_PWM1 4'h3
`define TPC_MODE_CMPC 4'h8
`define TPC_MODE_PWM2 4'hc
`endif

// *** hdl/tpc_pkg.sv ***
package tpc_pkg;
   typedef enum logic [1:0] {
      TPC_IDLE,
      TPC_CMPC,
      TPC_PWM1,
      TPC_PWM2
   } tpc_mode_t;
endpackage

// *** hdl/tpc_tick_if.sv ***
`timescale 1ns/100ps
// count-advance request between prescaler and counter core
interface tpc_tick_if;
   logic tick;
   logic [2:0] pre_sel;
   logic run;
   modport src (output tick, input pre_sel, input run);
   modport dst (input tick, output pre_sel, output run);
endinterface

// *** hdl/tpc_prescale.sv ***
`timescale 1ns/100ps
`include "tpc_params.svh"
// divides system clock by 2**pre_sel, one-cycle tick out
module tpc_prescale import tpc_pkg::*; (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // sync reset, active low
   tpc_tick_if.src tk // tick to counter
);
   typedef struct packed {
      logic [6:0] div;
   } tpc_pre_st_t;
   tpc_pre_st_t st_reg;
   tpc_pre_st_t st_next;
   logic [6:0] lim;

   // divider, held cleared while stopped so first tick is a full period
   always_comb begin
      st_next = st_reg;
      lim = 7'((8'h01 << tk.pre_sel) - 8'h01);
      tk.tick = 1'b0;
      if (!tk.run) begin
         st_next.div = 7'h00;
      end else if (st_reg.div >= lim) begin
         st_next.div = 7'h00;
         tk.tick = 1'b1;
      end else begin
         st_next.div = st_reg.div + 7'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule // tpc_prescale

// *** hdl/tpc_deadband.sv ***
`timescale 1ns/100ps
`include "tpc_params.svh"
// delays rising edges of one output by the dead band
module tpc_deadband import tpc_pkg::*; (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // sync reset, active low
   input wire logic raw_i, // undelayed level
   input wire logic [7:0] db_i, // dead band in clocks
   output logic out_o // delayed output
);
   typedef struct packed {
      logic [7:0] cnt;
      logic out;
   } tpc_db_st_t;
   tpc_db_st_t st_reg;
   tpc_db_st_t st_next;

   // falls follow at once; rises wait db_i clocks of steady high
   always_comb begin
      st_next = st_reg;
      if (!raw_i) begin
         st_next.out = 1'b0;
         st_next.cnt = 8'h00;
      end else if (!st_reg.out) begin
         if (st_reg.cnt >= db_i) begin
            st_next.out = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 8'h01;
         end
      end
   end

   // zero dead band passes the raw level in the same cycle
   assign out_o = (db_i == `TPC_DB_RST) ? raw_i : st_next.out;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule // tpc_deadband

// *** hdl/tpc_timer.sv ***
`timescale 1ns/100ps
`include "tpc_params.svh"
// Overview of operation
// - comparator mode: reload raises irq, restarts 0001
// - comparator mode: output toggles at reload
// - polarity picks comparator edge and start level
// - comparator mode: start count only first pass
// - single pwm counts prescaled clocks drives output
// - pwm: match toggles, reload interrupts restarts
// - polarity one: start high, match low
// - polarity zero: start low, match high
// - pwm: start count only first period
// - dual pwm: second pin is complement
// - dual pwm: rising edges delayed dead band
// - dual pwm repurposes input pin as output
// - comparator mode counts comparator transitions
// - comparator mode bypasses prescaler
// - counter wraps ffff to 0000
// - prescaler divides by 1 to 128
module tpc_timer import tpc_pkg::*; (
   input wire logic clk_i, // system clock 25 MHz
   input wire logic rst_n_i, // sync reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic cmp_out_i, // analog comparator output
   output logic tmr_out_o, // timer output pin
   output logic tmr_out_comp_o, // complementary output pin
   output logic tmr_in_sel_o, // high: shared pin is timer input
   output logic irq_o // reload interrupt pulse
);
   typedef struct packed {
      logic [7:0] ctl0;
      logic [7:0] ctl1;
      logic [15:0] cnt;
      logic [15:0] pwm;
      logic [15:0] rld;
      logic [7:0] db;
      logic cmp_q;
      logic out;
      logic irq;
      logic [31:0] rdata;
   } tpc_st_t;
   tpc_st_t st_reg;
   tpc_st_t st_next;

   tpc_tick_if tk ();
   tpc_mode_t mode;
   logic [3:0] mode_code;
   logic en;
   logic pol;
   logic wr;
   logic rd;
   logic hit;
   logic cmp_edge;
   logic step;
   logic at_rld;
   logic at_pwm;
   logic pwm_raw;
   logic pri_db;
   logic cmp_db;
   logic [1:0] leg_raw;
   logic [1:0] leg_db;

   // mode decode; unsupported codes park the counter
   assign mode_code = {st_reg.ctl1[`TPC_C1_MODEHI],
      st_reg.ctl0[`TPC_C0_MODE_HI:`TPC_C0_MODE_LO]};
   always_comb begin
      case (mode_code)
         `TPC_MODE_CMPC: mode = TPC_CMPC;
         `TPC_MODE_PWM1: mode = TPC_PWM1;
         `TPC_MODE_PWM2: mode = TPC_PWM2;
         default: mode = TPC_IDLE;
      endcase
   end
   assign en = st_reg.ctl0[`TPC_C0_EN];
   assign pol = st_reg.ctl0[`TPC_C0_POL];

   // prescaler runs only in clocked pwm modes
   assign tk.pre_sel = st_reg.ctl0[`TPC_C0_PRE_HI:`TPC_C0_PRE_LO];
   assign tk.run = en && (mode == TPC_PWM1 || mode == TPC_PWM2);
   tpc_prescale u_pre (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tk(tk)
   );

   // edge select follows polarity; input trusted below quarter clock
   assign cmp_edge = pol ? (!cmp_out_i && st_reg.cmp_q)
                         : (cmp_out_i && !st_reg.cmp_q);
   // comparator edges count directly, no prescale
   assign step = en && ((mode == TPC_CMPC) ? cmp_edge : tk.tick);
   assign at_rld = st_reg.cnt == st_reg.rld;
   assign at_pwm = st_reg.cnt == st_reg.pwm;

   // apb decode, zero wait states
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   always_comb begin
      case (paddr)
         `TPC_OFF_CTL0, `TPC_OFF_CTL1, `TPC_OFF_CNT,
         `TPC_OFF_PWM, `TPC_OFF_RLD, `TPC_OFF_DBND: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = st_reg.rdata;

   // counter, output level and register writes
   always_comb begin
      st_next = st_reg;
      st_next.irq = 1'b0;
      st_next.cmp_q = cmp_out_i;
      if (!en) begin
         st_next.out = pol;
      end else if (step) begin
         if (at_rld) begin
            st_next.cnt = `TPC_CNT_RESTART;
            st_next.irq = 1'b1;
            if (mode == TPC_CMPC) begin
               st_next.out = !st_reg.out;
            end else begin
               st_next.out = pol;
            end
         end else begin
            // natural 16-bit wrap past ffff
            st_next.cnt = st_reg.cnt + 16'h0001;
            if (mode != TPC_CMPC && at_pwm) begin
               st_next.out = !st_reg.out;
            end
         end
      end
      // software writes win over the count for the same cycle
      if (wr) begin
         case (paddr)
            `TPC_OFF_CTL0: st_next.ctl0 = pwdata[7:0];
            `TPC_OFF_CTL1: st_next.ctl1 = pwdata[7:0];
            `TPC_OFF_CNT: st_next.cnt = pwdata[15:0];
            `TPC_OFF_PWM: st_next.pwm = pwdata[15:0];
            `TPC_OFF_RLD: st_next.rld = pwdata[15:0];
            `TPC_OFF_DBND: begin
               // clamp to the largest supported dead band
               if (pwdata[7:0] > `TPC_DB_MAX) begin
                  st_next.db = `TPC_DB_MAX;
               end else begin
                  st_next.db = pwdata[7:0];
               end
            end
            default: st_next.rdata = st_reg.rdata;
         endcase
      end
      // read data captured in setup, valid in access phase
      if (rd) begin
         case (paddr)
            `TPC_OFF_CTL0: st_next.rdata = {24'h000000, st_reg.ctl0};
            `TPC_OFF_CTL1: st_next.rdata = {24'h000000, st_reg.ctl1};
            `TPC_OFF_CNT: st_next.rdata = {16'h0000, st_reg.cnt};
            `TPC_OFF_PWM: st_next.rdata = {16'h0000, st_reg.pwm};
            `TPC_OFF_RLD: st_next.rdata = {16'h0000, st_reg.rld};
            `TPC_OFF_DBND: st_next.rdata = {24'h000000, st_reg.db};
            default: st_next.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_reg.ctl0 <= `TPC_CTL_RST;
         st_reg.ctl1 <= `TPC_CTL_RST;
         st_reg.cnt <= `TPC_CNT_RST;
         st_reg.pwm <= `TPC_PWM_RST;
         st_reg.rld <= `TPC_RLD_RST;
         st_reg.db <= `TPC_DB_RST;
         st_reg.cmp_q <= 1'b0;
         st_reg.out <= 1'b0;
         st_reg.irq <= 1'b0;
         st_reg.rdata <= 32'h00000000;
      end else begin
         st_reg <= st_next;
      end
   end

   // complementary pair, each leg with its own rising-edge delay
   assign pwm_raw = st_reg.out;
   assign leg_raw = {!pwm_raw, pwm_raw};
   for (genvar g = 0; g < 2; g++) begin : g_leg
      tpc_deadband u_db (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .raw_i(leg_raw[g]),
         .db_i(st_reg.db),
         .out_o(leg_db[g])
      );
   end
   assign pri_db = leg_db[0];
   assign cmp_db = leg_db[1];

   // pin outputs; dead band applies only in dual mode
   assign tmr_out_o = (mode == TPC_PWM2) ? pri_db : st_reg.out;
   assign tmr_out_comp_o = (mode == TPC_PWM2) ? cmp_db : 1'b0;
   assign tmr_in_sel_o = (mode != TPC_PWM2);
   assign irq_o = st_reg.irq;
endmodule // tpc_timer

// *** test/tpc_cmp_src.sv ***
`timescale 1ns/100ps
// comparator stand-in on the far side of the slice
module tpc_cmp_src (
   input wire logic clk_i, // system clock
   input wire logic en_i, // toggling on
   output logic cmp_o // comparator level
);
   logic [1:0] ph_reg = 2'd0;
   logic lvl_reg = 1'b0;
   assign cmp_o = lvl_reg;
   // four clocks between edges keeps it under the quarter-rate ceiling
   always @(posedge clk_i) begin
      ph_reg <= en_i ? ph_reg + 2'd1 : 2'd0;
      if (en_i && ph_reg == 2'd3)
         lvl_reg <= !lvl_reg;
   end
endmodule // tpc_cmp_src

// *** test/tpc_monitor.sv ***
`timescale 1ns/100ps
`include "tpc_params.svh"
// port-level checks of the timer slice
module tpc_monitor import tpc_pkg::*; (
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // reset
   input wire logic psel, // select
   input wire logic penable, // access
   input wire logic pwrite, // write
   input wire logic [11:0] paddr, // address
   input wire logic [31:0] pwdata, // write data
   input wire logic pslverr, // error
   input wire logic tmr_out_o, // output
   input wire logic tmr_out_comp_o, // complement
   input wire logic tmr_in_sel_o, // pin role
   input wire logic irq_o // interrupt
);
   logic [7:0] c0_reg;
   logic [7:0] db_reg;
   logic hi_reg;
   logic dual;
   logic pwm1;
   assign dual = {hi_reg, c0_reg[2:0]} == `TPC_MODE_PWM2;
   assign pwm1 = {hi_reg, c0_reg[2:0]} == `TPC_MODE_PWM1;
   // shadow of mode and band, so checks know the setup
   always_ff @(posedge clk_i)
      if (!rst_n_i) {c0_reg, db_reg, hi_reg} <= 17'h0;
      else if (psel && penable && pwrite) begin
         if (paddr == `TPC_OFF_CTL0) c0_reg <= pwdata[7:0];
         if (paddr == `TPC_OFF_CTL1) hi_reg <= pwdata[7];
         if (paddr == `TPC_OFF_DBND) db_reg <= pwdata[7:0];
      end
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_irq_one_pulse: assert property (irq_o |=> !irq_o)
      else $error("interrupt longer than one cycle");
   a_no_overlap: assert property (!(tmr_out_o && tmr_out_comp_o))
      else $error("both outputs high");
   a_comp_quiet: assert property (tmr_in_sel_o |-> !tmr_out_comp_o)
      else $error("complement driven while pin is input");
   a_pin_dual: assert property (dual[*2] |-> !tmr_in_sel_o)
      else $error("pin not reassigned in dual mode");
   a_zero_band: assert property ((dual && c0_reg[7] && db_reg == 8'h00)[*3]
      |-> tmr_out_comp_o == !tmr_out_o)
      else $error("complement lags with zero band");
   a_idle_level: assert property ((!c0_reg[7] && !dual)[*2]
      |-> tmr_out_o == c0_reg[6])
      else $error("idle level is not the polarity");
   a_reload_edge: assert property (pwm1 && c0_reg[7] && $past(c0_reg[7])
      && tmr_out_o != $past(tmr_out_o) && tmr_out_o == c0_reg[6]
      |-> ##[0:2] irq_o)
      else $error("return to start level without reload");
   a_irq_stopped: assert property ((!c0_reg[7])[*3] |-> !irq_o)
      else $error("interrupt while disabled");
   c_irq: cover property (irq_o);
   c_dual: cover property (dual && c0_reg[7] && tmr_out_comp_o);
   c_err: cover property (psel && penable && pslverr);
endmodule // tpc_monitor
bind tpc_timer tpc_monitor mon (
   .clk_i(clk_i),
   .rst_n_i(rst_n_i),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pslverr(pslverr),
   .tmr_out_o(tmr_out_o),
   .tmr_out_comp_o(tmr_out_comp_o),
   .tmr_in_sel_o(tmr_in_sel_o),
   .irq_o(irq_o)
);

// *** test/tb.sv ***
`timescale 1ns/100ps
`include "tpc_params.svh"
`define CHK(n, e, s) begin \
   num_checks++; \
   if ((s) !== (e)) begin \
      err_total++; \
      $display("BAD %s exp %0d got %0d", n, e, s); \
   end \
end
module tb;
   logic clk_i = 1'b0, rst_n_i = 1'b0, cmp_en = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, cmp_out_i, tmr_out_o, tmr_out_comp_o;
   logic tmr_in_sel_o, irq_o, er, pol;
   logic [3:0] m;
   logic [2:0] pre;
   integer seed = 32'h81037dad;
   int err_total = 0, num_checks = 0, cyc = 0;
   int p, r, db, h0, per, hi, chi;
   int exp_q[$];
   tpc_timer dut (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .cmp_out_i(cmp_out_i),
      .tmr_out_o(tmr_out_o),
      .tmr_out_comp_o(tmr_out_comp_o),
      .tmr_in_sel_o(tmr_in_sel_o),
      .irq_o(irq_o)
   );
   tpc_cmp_src src (.clk_i(clk_i), .en_i(cmp_en), .cmp_o(cmp_out_i));
   initial forever #20 clk_i = !clk_i;
   // hang guard, well above the longest case
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         complete_run();
      end
   end
   task complete_run();
      if (err_total == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one apb transfer; result left in rd and er
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1)
         @(posedge clk_i);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // disable first, load everything, enable last
   task automatic cfg(input int st);
      logic [7:0] c0;
      c0 = {1'b0, pol, pre, m[2:0]};
      apb(1'b1, `TPC_OFF_CTL0, {24'h0, c0});
      apb(1'b1, `TPC_OFF_CTL1, {24'h0, m[3], 7'h0});
      apb(1'b1, `TPC_OFF_CNT, st);
      apb(1'b1, `TPC_OFF_PWM, p);
      apb(1'b1, `TPC_OFF_DBND, db);
      apb(1'b1, `TPC_OFF_RLD, r);
      apb(1'b1, `TPC_OFF_CTL0, {24'h0, c0 | 8'h80});
   endtask
   // cycles and high counts up to the next interrupt
   task automatic meas();
      {per, hi, chi} = 0;
      do begin
         @(posedge clk_i);
         per++;
         hi += tmr_out_o;
         chi += tmr_out_comp_o;
      end while (irq_o !== 1'b1);
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      cmp_en <= 1'b1;
      apb(1'b0, 12'h018, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
      apb(1'b1, `TPC_OFF_DBND, 32'hff);
      apb(1'b0, `TPC_OFF_DBND, 32'h0);
      `CHK("band clamp", 32'h80, rd)
      // pairs: single pwm, dual pwm, comparator counter
      for (int i = 0; i < 6; i++) begin
         pol = i[0];
         m = i < 2 ? `TPC_MODE_PWM1 : i < 4 ? `TPC_MODE_PWM2 : `TPC_MODE_CMPC;
         pre = i < 2 ? 3'($random(seed)) : 3'd0;
         db = i == 3 ? 1 + ($random(seed) & 7) : 0;
         p = 9 + ($random(seed) & 7);
         r = p + 9 + ($random(seed) & 7);
         // reference period: prescaled reload, or eight clocks per edge
         exp_q.push_back(i < 4 ? r << pre : 8 * r);
         cfg(1 + (($random(seed) & 255) % (r - 1)));
         meas();
         meas();
         h0 = hi;
         meas();
         `CHK("pin role", i / 2 != 1, tmr_in_sel_o)
         if (i < 4) begin
            `CHK("period", exp_q[0], per)
            `CHK("high", (pol ? p << pre : (r - p) << pre) - db, hi)
         end else begin
            `CHK("cmp period", exp_q[0], per)
            `CHK("toggle sum", per, hi + h0)
            `CHK("edge level", !pol, cmp_out_i)
         end
         void'(exp_q.pop_front());
         if (i == 2) `CHK("comp sum", per, hi + chi)
         if (i == 3) `CHK("band gap", per - 2 * db, hi + chi)
      end
      // a start past the reload wraps through 0000, two extra steps
      pol = 1'b0;
      m = `TPC_MODE_PWM1;
      pre = 3'd0;
      p = 1;
      r = 3;
      db = 0;
      cfg(1);
      meas();
      h0 = per;
      cfg(32'hffff);
      meas();
      `CHK("wrap pass", h0 + 2, per)
      complete_run();
   end
endmodule // tb
